// ### lcid_assertions.sv
`timescale 1ns/1ps
module lcid_assertions
	import lcid_pkg::*;
#(
	parameter logic [CNT_W-1:0] HOLD_DELAY_CYCLES = CNT_W'(HOLD_DELAY_CYC),
	parameter logic [CNT_W-1:0] PULSE_GAP_CYCLES  = CNT_W'(PULSE_GAP_CYC),
	parameter logic [CNT_W-1:0] HALF_BIT_CYCLES   = CNT_W'(HALF_BIT_CYC),
	parameter logic [CNT_W-1:0] BIT_CYCLES        = CNT_W'(BIT_CYC)
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_line,
	input  wire logic       o_char_received_flag,
	input  wire logic       o_idle_line_flag,
	input  wire logic       o_line_open_flag,
	input  wire logic [7:0] o_rx_code,
	input  wire logic       o_shift_pulse,
	input  wire logic       o_timer_pulse
);
	localparam int HOLD = int'(HOLD_DELAY_CYCLES); // first pulse delay
	localparam int GAP  = int'(PULSE_GAP_CYCLES);  // second pulse gap
	localparam int HALF = int'(HALF_BIT_CYCLES);   // start qualify time
	localparam int BITC = int'(BIT_CYCLES);        // bit period
	int            char_cnt;                       // cycles with char flag up
	int            gap_cnt;                        // cycles since timer pulse
	int            sp_cnt;                         // cycles of unbroken space
	// ****************************************
	// helper counters and checks
	// ****************************************
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			char_cnt <= 0;
			gap_cnt  <= 0;
			sp_cnt   <= 0;
		end
		else begin
			char_cnt <= o_char_received_flag ? char_cnt + 1 : 0;
			gap_cnt  <= o_timer_pulse ? 0 : gap_cnt + 1;
			sp_cnt   <= i_line ? 0 : sp_cnt + 1;
		end
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	chk_pulse_clears: assert property (
		o_timer_pulse |-> !o_char_received_flag && !o_line_open_flag && o_rx_code == 8'hFF)
		else $error("timer pulse left flags or stages set");
	chk_first_no_idle: assert property (
		o_timer_pulse && $past(o_char_received_flag) |-> !o_idle_line_flag)
		else $error("first pulse set idle");
	chk_idle_on_pulse: assert property (
		$rose(o_idle_line_flag) |-> o_timer_pulse)
		else $error("idle set without pulse");
	chk_idle_gap: assert property (
		$rose(o_idle_line_flag) && !$past(o_line_open_flag) |-> gap_cnt inside {[GAP-2:GAP+2]})
		else $error("second pulse gap wrong");
	chk_idle_blocks: assert property (
		$past(o_idle_line_flag) && o_idle_line_flag && !$past(o_line_open_flag) |-> !o_timer_pulse)
		else $error("timer pulsed while idle");
	chk_busy_start: assert property (
		$fell(o_idle_line_flag) |-> o_shift_pulse && sp_cnt >= HALF)
		else $error("idle cleared without qualified shift");
	chk_frame_end: assert property (
		$rose(o_char_received_flag) || $rose(o_line_open_flag) |-> o_shift_pulse)
		else $error("frame flag without shift");
	chk_open_mute: assert property (
		$past(o_line_open_flag) && o_line_open_flag |-> !o_shift_pulse)
		else $error("shift during open line");
	chk_char_hold: assert property (
		$fell(o_char_received_flag) |-> char_cnt inside {[HOLD-1:HOLD+4]})
		else $error("char flag hold time wrong");
	chk_bit_space: assert property (
		o_shift_pulse && !o_char_received_flag && !o_line_open_flag |-> ##BITC o_shift_pulse)
		else $error("shift spacing wrong");
	cov_char: cover property ($rose(o_char_received_flag));
	cov_open: cover property ($rose(o_line_open_flag));
	cov_idle: cover property ($rose(o_idle_line_flag));
endmodule

// ### lcid_pkg.sv
package lcid_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS  = 10;     // 100 MHz system clock
	localparam int unsigned NS_PER_US      = 1000;   // unit conversion
	localparam int unsigned HOLD_DELAY_US  = 13000;  // 13 ms to first timer pulse
	localparam int unsigned PULSE_GAP_US   = 10000;  // 10 ms to second timer pulse
	localparam int unsigned HALF_BIT_US    = 4540;   // 4.54 ms start bit qualify
	localparam int unsigned BIT_US         = 9090;   // 9.09 ms bit period
	localparam int unsigned CNT_W          = 24;     // counter width

	// least times round up to whole cycles
	localparam int unsigned HOLD_DELAY_CYC =
		(HOLD_DELAY_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PULSE_GAP_CYC  =
		(PULSE_GAP_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HALF_BIT_CYC   =
		(HALF_BIT_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BIT_CYC        =
		(BIT_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [3:0]  REG_STATUS   = 4'h0;   // flags, read only
	localparam logic [3:0]  REG_DATA     = 4'h4;   // code levels, read only
	localparam logic [3:0]  REG_CTRL     = 4'h8;   // control, read/write
	localparam int unsigned ST_CHAR      = 0;      // status: received flag
	localparam int unsigned ST_IDLE      = 1;      // status: idle flag
	localparam int unsigned ST_OPEN      = 2;      // status: open line flag
	localparam int unsigned ST_FINAL     = 3;      // status: final stage space
	localparam int unsigned ST_TIMER     = 4;      // status: timer running
	localparam int unsigned CTRL_ENABLE  = 0;      // ctrl: line input enable
	localparam int unsigned CTRL_KEY     = 1;      // ctrl: soft start key
	localparam logic [1:0]  CTRL_RESET   = 2'h1;   // enabled, key released
	localparam logic        LINE_MARK    = 1'b1;   // line level for mark
	localparam logic [9:1]  STAGES_MARK  = 9'h1FF; // all stages holding mark

	// ****************************************
	// state types
	// ****************************************
	typedef enum logic [2:0] {
		PACE_OFF  = 3'h1,  // pacing held
		PACE_HALF = 3'h2,  // waiting half a bit
		PACE_BIT  = 3'h4   // pulsing every bit
	} lcid_pace_t;

	typedef enum logic [2:0] {
		TMR_OFF   = 3'h1,  // timer reset
		TMR_DELAY = 3'h2,  // counting to first pulse
		TMR_GAP   = 3'h4   // counting to next pulse
	} lcid_tmr_t;

	typedef struct packed {
		logic             line_meta;   // synchroniser first stage
		logic             line_sync;   // synchronised line level
		logic [9:1]       stage;       // stages 9 (entry) .. 1, 1 = mark
		logic             final_space; // final stage holds the start space
		logic             char_received_flag;
		logic             idle_line_flag;
		logic             line_open_flag;
		lcid_pace_t       pace;        // bit pacing phase
		logic [CNT_W-1:0] pace_cnt;    // bit pacing counter
		lcid_tmr_t        tmr;         // hold-off timer phase
		logic [CNT_W-1:0] tmr_cnt;     // hold-off timer counter
		logic             timer_pulse; // registered timer pulse
		logic             shift_pulse; // registered shift pulse
		logic [1:0]       ctrl;        // control register
		logic             waitreq;     // bus wait request
		logic [31:0]      rdata;       // bus read data
	} lcid_state_t;

	localparam lcid_state_t ST_RESET = '{
		line_meta:          LINE_MARK,
		line_sync:          LINE_MARK,
		stage:              STAGES_MARK,
		final_space:        1'b1,
		char_received_flag: 1'b0,
		idle_line_flag:     1'b1,
		line_open_flag:     1'b1,
		pace:               PACE_OFF,
		pace_cnt:           '0,
		tmr:                TMR_OFF,
		tmr_cnt:            '0,
		timer_pulse:        1'b0,
		shift_pulse:        1'b0,
		ctrl:               CTRL_RESET,
		waitreq:            1'b1,
		rdata:              '0
	};

endpackage

// ### lcid_station.sv
`timescale 1ns/1ps
module lcid_station #(
	parameter int BIT = 91 // cycles per line bit
) (
	input  wire logic       i_clk,
	input  wire logic       i_send,
	input  wire logic [7:0] i_code,
	input  wire logic       i_break,
	output logic            o_line
);
	logic [10:0] frame; // start, levels 1..8, two stops
	int          k;     // bit index in frame
	// ****************************************
	// sending station
	// ****************************************
	always @(posedge i_clk) begin
		if (i_send) begin
			// start space, eight levels, two stop marks
			frame = {2'b11, i_code, 1'b0};
			for (k = 0; k < 11; k++) begin
				o_line <= frame[k];
				repeat (BIT) @(posedge i_clk);
			end
		end
		else begin
			// rests at mark, break holds space
			o_line <= !i_break;
		end
	end
endmodule

// ### lcid_top.sv
`timescale 1ns/1ps
module lcid_top
	import lcid_pkg::*;
#(
	parameter logic [CNT_W-1:0] HOLD_DELAY_CYCLES = CNT_W'(HOLD_DELAY_CYC),
	parameter logic [CNT_W-1:0] PULSE_GAP_CYCLES  = CNT_W'(PULSE_GAP_CYC),
	parameter logic [CNT_W-1:0] HALF_BIT_CYCLES   = CNT_W'(HALF_BIT_CYC),
	parameter logic [CNT_W-1:0] BIT_CYCLES        = CNT_W'(BIT_CYC)
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_line,
	input  wire logic        i_start_key,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	output logic             o_char_received_flag,
	output logic             o_idle_line_flag,
	output logic             o_line_open_flag,
	output logic      [7:0]  o_rx_code,
	output logic             o_shift_pulse,
	output logic             o_timer_pulse
);

	// ****************************************
	// state and working signals
	// ****************************************
	lcid_state_t      st;          // all registered state
	lcid_state_t      next_st;     // next value of all state
	logic             line_mark;   // gated line input, 1 = mark
	logic             pace_run;    // bit pacing released
	logic             shift;       // shift pulse this cycle
	logic             reach_final; // start space arrives in final stage
	logic             key;         // combined start key
	logic             idle_ok;     // idle-hold gate passes
	logic             busy_ok;     // busy-hold gate passes
	logic             tmr_run;     // timer release gate passes
	logic             tpulse;      // timer pulse this cycle
	logic             idle_armed;  // idle flag may be set by a pulse
	logic             req;         // bus request present
	logic [31:0]      rd_word;     // decoded read data
	logic [CNT_W-1:0] pace_tgt;    // pacing terminal count
	logic [CNT_W-1:0] tmr_tgt;     // timer terminal count

	// ****************************************
	// next state logic
	// ****************************************
	always_comb begin
		next_st = st;

		// two flop synchroniser on the line
		// line synchronised
		next_st.line_meta = i_line;
		next_st.line_sync = st.line_meta;

		// line input gate: open line or disable blinds it to mark
		// open forces mark
		if (st.line_open_flag || !st.ctrl[CTRL_ENABLE]) begin
			line_mark = LINE_MARK;
		end else begin
			line_mark = (st.line_sync == LINE_MARK);
		end

		// pace control gate: space on line or character in flight
		// stop at final
		pace_run = !line_mark || !st.final_space;

		// ------------------------------------
		// bit pacing generator
		// ------------------------------------
		shift    = 1'b0;
		pace_tgt = (st.pace == PACE_BIT) ? BIT_CYCLES : HALF_BIT_CYCLES;
		if (!pace_run) begin
			// held: delay restarts on the next space
			next_st.pace     = PACE_OFF;
			next_st.pace_cnt = '0;
		end else begin
			case (st.pace)
				PACE_OFF: begin
					next_st.pace     = PACE_HALF;
					next_st.pace_cnt = CNT_W'(1);
				end
				PACE_HALF,
				PACE_BIT: begin
					if (st.pace_cnt >= pace_tgt - CNT_W'(1)) begin
						shift            = 1'b1;
						next_st.pace     = PACE_BIT;
						next_st.pace_cnt = '0;
					end else begin
						next_st.pace_cnt = st.pace_cnt + CNT_W'(1);
					end
				end
				default: begin
					// illegal code: back to held
					next_st.pace     = PACE_OFF;
					next_st.pace_cnt = '0;
				end
			endcase
		end

		// ------------------------------------
		// receive register
		// ------------------------------------
		// start space arrives when a space shifts out of stage 1
		reach_final = shift && !st.final_space && !st.stage[1];
		if (shift) begin
			// nine stages plus final, second stop never stored
			next_st.stage       = {line_mark, st.stage[9:2]};
			next_st.final_space = !st.stage[1];
			if (st.final_space && st.stage[1]) begin
				next_st.idle_line_flag = 1'b0;
			end
		end

		// character or open line when the start space lands
		if (reach_final) begin
			if (line_mark) begin
				next_st.char_received_flag = 1'b1;
			end else begin
				// space at entry, received flag kept
				next_st.line_open_flag = 1'b1;
			end
		end

		// ------------------------------------
		// hold-off timer gating
		// ------------------------------------
		key = i_start_key || st.ctrl[CTRL_KEY];
		idle_ok = st.line_open_flag || !st.idle_line_flag;
		// busy gate from open, received flag and line
		// start key when not idle or open
		busy_ok = st.line_open_flag
			|| (line_mark && (st.char_received_flag || !st.idle_line_flag))
			|| (key && !st.idle_line_flag && !st.line_open_flag);
		// final stage, idle and busy gates
		// received flag with mark releases timer
		tmr_run = st.final_space && idle_ok && busy_ok;

		// ------------------------------------
		// hold-off timer
		// ------------------------------------
		tpulse  = 1'b0;
		tmr_tgt = (st.tmr == TMR_GAP) ? PULSE_GAP_CYCLES : HOLD_DELAY_CYCLES;
		if (!tmr_run) begin
			next_st.tmr     = TMR_OFF;
			next_st.tmr_cnt = '0;
		end else begin
			case (st.tmr)
				TMR_OFF: begin
					next_st.tmr     = TMR_DELAY;
					next_st.tmr_cnt = CNT_W'(1);
				end
				TMR_DELAY,
				TMR_GAP: begin
					// 13 ms then 10 ms pulses
					if (st.tmr_cnt >= tmr_tgt - CNT_W'(1)) begin
						tpulse          = 1'b1;
						next_st.tmr     = TMR_GAP;
						next_st.tmr_cnt = '0;
					end else begin
						next_st.tmr_cnt = st.tmr_cnt + CNT_W'(1);
					end
				end
				default: begin
					// illegal code: back to reset
					next_st.tmr     = TMR_OFF;
					next_st.tmr_cnt = '0;
				end
			endcase
		end

		// ------------------------------------
		// timer pulse effects
		// ------------------------------------
		// received flag disarms idle
		idle_armed = !st.char_received_flag;
		if (tpulse) begin
			// stages back to mark, open cleared
			next_st.stage[9:2]     = STAGES_MARK[9:2];
			next_st.stage[1]       = 1'b1;
			next_st.line_open_flag = 1'b0;
			next_st.char_received_flag = 1'b0;
			// idle only on a quiet line
			if (idle_armed) begin
				next_st.idle_line_flag = 1'b1;
			end
		end
		next_st.timer_pulse = tpulse;
		next_st.shift_pulse = shift;

		// ------------------------------------
		// register bus slave
		// ------------------------------------
		req = i_avs_read || i_avs_write;
		case (i_avs_address)
			REG_STATUS: begin
				rd_word                = '0;
				rd_word[ST_CHAR]       = st.char_received_flag;
				rd_word[ST_IDLE]       = st.idle_line_flag;
				rd_word[ST_OPEN]       = st.line_open_flag;
				rd_word[ST_FINAL]      = st.final_space;
				rd_word[ST_TIMER]      = (st.tmr != TMR_OFF);
			end
			REG_DATA: begin
				rd_word = {24'h000000, st.stage[8:1]};
			end
			REG_CTRL: begin
				rd_word = {30'h0, st.ctrl};
			end
			default: begin
				// unmapped reads as zero
				rd_word = '0;
			end
		endcase
		// one wait state: answer on the second request cycle
		next_st.waitreq = !(req && st.waitreq);
		if (req && st.waitreq && i_avs_read) begin
			next_st.rdata = rd_word;
		end
		// write lands on the edge where wait request is low
		if (i_avs_write && !st.waitreq && (i_avs_address == REG_CTRL)) begin
			next_st.ctrl = i_avs_writedata[1:0];
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// outputs, all straight from flops
	// ****************************************
	assign o_avs_readdata       = st.rdata;
	assign o_avs_waitrequest    = st.waitreq;
	assign o_char_received_flag = st.char_received_flag;
	assign o_idle_line_flag     = st.idle_line_flag;
	assign o_line_open_flag     = st.line_open_flag;
	assign o_rx_code            = st.stage[8:1];
	assign o_shift_pulse        = st.shift_pulse;
	assign o_timer_pulse        = st.timer_pulse;

endmodule

// ### tb_line_character_and_idle_detect.sv
`timescale 1ns/1ps
module tb_line_character_and_idle_detect
	import lcid_pkg::*;
;
	localparam int HALF            = 45;    // shortened half bit
	localparam int BITC            = 91;    // shortened bit
	logic          i_clk           = 1'b0;  // system clock
	logic          i_rst           = 1'b1;  // async reset
	wire           i_line;                  // line from station
	logic          i_start_key     = 1'b0;  // key released
	logic [3:0]    i_avs_address   = 4'h0;
	logic          i_avs_read      = 1'b0;
	logic          i_avs_write     = 1'b0;
	logic [31:0]   i_avs_writedata = 32'h0;
	logic [31:0]   o_avs_readdata;
	logic          o_avs_waitrequest;
	logic          o_char_received_flag;
	logic          o_idle_line_flag;
	logic          o_line_open_flag;
	logic [7:0]    o_rx_code;
	logic          o_shift_pulse;
	logic          o_timer_pulse;
	logic          send            = 1'b0;  // station send request
	logic          brk             = 1'b0;  // station break
	logic [7:0]    code            = 8'h00; // code to send
	logic [31:0]   q;                       // last read data
	int            tp_n            = 0;     // timer pulses seen
	int            tp_a;                    // pulse count snapshot
	int            sh_n            = 0;     // shift pulses seen
	int            sh_a;                    // shift count snapshot
	int            bad_count       = 0;
	int            total_checks    = 0;
	lcid_top #(.HOLD_DELAY_CYCLES(24'h82), .PULSE_GAP_CYCLES(24'h64),
		.HALF_BIT_CYCLES(24'h2D), .BIT_CYCLES(24'h5B)) DUT (.i_clk, .i_rst, .i_line,
		.i_start_key, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
		.o_avs_readdata, .o_avs_waitrequest, .o_char_received_flag, .o_idle_line_flag,
		.o_line_open_flag, .o_rx_code, .o_shift_pulse, .o_timer_pulse);
	lcid_station #(.BIT(BITC)) u_station (.i_clk, .i_send(send), .i_code(code),
		.i_break(brk), .o_line(i_line));
	// ****************************************
	// clock, tasks and tests
	// ****************************************
	always #5 i_clk = ~i_clk;
	// count timer and shift pulses
	always @(posedge i_clk) begin
		if (o_timer_pulse === 1'b1)
			tp_n++;
		if (o_shift_pulse === 1'b1)
			sh_n++;
	end
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
		@(posedge i_clk);
		i_avs_address   <= a;
		i_avs_write     <= w;
		i_avs_read      <= !w;
		i_avs_writedata <= d;
		@(posedge i_clk);
		while (o_avs_waitrequest !== 1'b0)
			@(posedge i_clk);
		q = o_avs_readdata;
		i_avs_read  <= 1'b0;
		i_avs_write <= 1'b0;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		cmp(q & m, e);
	endtask
	task automatic complete_run;
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (40000) @(posedge i_clk);
		bad_count++;
		complete_run();
	end
	// main sequence
	initial begin
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		rchk(REG_CTRL, 32'h3, 32'h1);
		rchk(REG_STATUS, 32'h1F, 32'h1E);
		bus(4'hC, 1'b1, 32'h3);
		rchk(4'hC, 32'hFFFFFFFF, 32'h0);
		@(posedge o_timer_pulse);
		rchk(REG_STATUS, 32'h1F, 32'h0A);
		brk <= 1'b1;
		repeat (HALF / 2) @(posedge i_clk);
		brk <= 1'b0;
		repeat (BITC) @(posedge i_clk);
		rchk(REG_STATUS, 32'h1F, 32'h0A);
		bus(REG_CTRL, 1'b1, 32'h2);
		rchk(REG_CTRL, 32'h3, 32'h2);
		send <= 1'b1;
		@(posedge i_clk);
		send <= 1'b0;
		repeat (12 * BITC) @(posedge i_clk);
		rchk(REG_STATUS, 32'h1F, 32'h0A);
		bus(REG_CTRL, 1'b1, 32'h1);
		code <= 8'hA5;
		send <= 1'b1;
		@(posedge i_clk);
		send <= 1'b0;
		@(posedge o_char_received_flag);
		rchk(REG_STATUS, 32'h1F, 32'h19);
		rchk(REG_DATA, 32'hFF, 32'hA5);
		cmp({24'h000000, o_rx_code}, 32'hA5);
		@(posedge o_timer_pulse);
		rchk(REG_STATUS, 32'h1F, 32'h18);
		rchk(REG_DATA, 32'hFF, 32'hFF);
		@(posedge o_timer_pulse);
		rchk(REG_STATUS, 32'h1F, 32'h0A);
		code <= 8'h3C;
		send <= 1'b1;
		@(posedge o_char_received_flag);
		code <= 8'hC3;
		tp_a = tp_n;
		sh_a = sh_n;
		rchk(REG_DATA, 32'hFF, 32'h3C);
		@(posedge o_char_received_flag);
		send <= 1'b0;
		cmp(tp_n - tp_a, 32'h1);
		cmp(sh_n - sh_a, 32'hA);
		rchk(REG_DATA, 32'hFF, 32'hC3);
		@(posedge o_timer_pulse);
		@(posedge o_timer_pulse);
		brk <= 1'b1;
		@(posedge o_line_open_flag);
		rchk(REG_STATUS, 32'h1F, 32'h1C);
		@(posedge o_timer_pulse);
		rchk(REG_STATUS, 32'h1F, 32'h0A);
		brk <= 1'b0;
		complete_run();
	end
endmodule
bind lcid_top lcid_assertions #(.HOLD_DELAY_CYCLES(HOLD_DELAY_CYCLES),
	.PULSE_GAP_CYCLES(PULSE_GAP_CYCLES), .HALF_BIT_CYCLES(HALF_BIT_CYCLES),
	.BIT_CYCLES(BIT_CYCLES)) u_chk (.i_clk, .i_rst, .i_line, .o_char_received_flag,
	.o_idle_line_flag, .o_line_open_flag, .o_rx_code, .o_shift_pulse, .o_timer_pulse);
